// [design/bsma_pkg.sv]
package bsma_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // Dual-decoded single-access RAM windows, in words.
  localparam logic [ADDR_W-1:0] HIGH_RAM_LOW_BASE  = 22'h00a000;
  localparam logic [ADDR_W-1:0] HIGH_RAM_HIGH_BASE = 22'h3fa000;
  localparam logic [ADDR_W-1:0] HIGH_RAM_SIZE      = 22'h002000;
  localparam logic [ADDR_W-1:0] LOW0_RAM_LOW_BASE  = 22'h008000;
  localparam logic [ADDR_W-1:0] LOW0_RAM_HIGH_BASE = 22'h3f8000;
  localparam logic [ADDR_W-1:0] LOW1_RAM_LOW_BASE  = 22'h009000;
  localparam logic [ADDR_W-1:0] LOW1_RAM_HIGH_BASE = 22'h3f9000;
  localparam logic [ADDR_W-1:0] LOW_RAM_SIZE       = 22'h001000;
  localparam int                HIGH_RAM_DEPTH     = 8192;
  localparam int                LOW_RAM_DEPTH      = 4096;

  // Stack reach and the upper 64K-word range.
  localparam logic [ADDR_W-1:0] SP_LIMIT           = 22'h010000;
  localparam logic [ADDR_W-1:0] UPPER_RANGE_BASE   = 22'h3f0000;

  // Code security password words and boot entry points.
  localparam logic [ADDR_W-1:0] PW_FIRST           = 22'h3f7ff8;
  localparam logic [ADDR_W-1:0] PW_LAST            = 22'h3f7fff;
  localparam logic [ADDR_W-1:0] FLASH_ENTRY        = 22'h3f7ff6;
  localparam logic [ADDR_W-1:0] LOWEST_RAM_ENTRY   = 22'h000000;
  localparam logic [ADDR_W-1:0] OTP_ENTRY_DEFAULT  = 22'h3f0000;

  typedef enum logic [2:0] {
    BSMA_BOOT_PARALLEL = 3'h0,
    BSMA_BOOT_OTP      = 3'h1,
    BSMA_BOOT_RAM      = 3'h2,
    BSMA_BOOT_CAN      = 3'h3,
    BSMA_BOOT_TWO_WIRE = 3'h4,
    BSMA_BOOT_SYNC_SER = 3'h5,
    BSMA_BOOT_ASYNC    = 3'h6,
    BSMA_BOOT_FLASH    = 3'h7
  } bsma_boot_mode_t;

  typedef enum logic [1:0] {
    BSMA_SEL_NONE = 2'h0,
    BSMA_SEL_HIGH = 2'h1,
    BSMA_SEL_LOW0 = 2'h2,
    BSMA_SEL_LOW1 = 2'h3
  } bsma_sel_t;

  typedef enum logic {
    BSMA_ST_WAIT = 1'b0,
    BSMA_ST_DONE = 1'b1
  } bsma_boot_st_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              sp_access;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bsma_req_t;

  typedef struct packed {
    logic              valid;
    logic              hit;
    logic              sp_fault;
    logic              upper_alias;
    logic              pw_hit;
    logic [DATA_W-1:0] rdata;
  } bsma_rsp_t;

  typedef struct packed {
    logic boot_select_first_pin;
    logic boot_select_second_pin;
    logic boot_select_third_pin;
  } bsma_pins_t;

  typedef struct packed {
    logic              valid;
    bsma_boot_mode_t   mode;
    logic              jump;
    logic              reserved;
    logic [ADDR_W-1:0] entry;
  } bsma_boot_t;

endpackage : bsma_pkg

// [design/bsma_ram.sv]
`timescale 1ns/100ps
module bsma_ram
  import bsma_pkg::*;
#(
  parameter int DEPTH = LOW_RAM_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Access port
  input  wire logic              we,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  if (DEPTH != (1 << AW)) begin : g_depth_check
    $error("bsma_ram depth must be a power of two");
  end

  logic [DATA_W-1:0] mem      [DEPTH];
  logic [DATA_W-1:0] next_mem [DEPTH];
  logic [DATA_W-1:0] next_rdata;

  // Read returns the stored word before any write in the same cycle.
  always_comb begin
    next_mem   = mem;
    next_rdata = mem[addr];
    if (we) begin
      next_mem[addr] = wdata;
    end
  end

  // Storage holds data only, so it carries no reset and stays small.
  always_ff @(posedge sys_clk) begin
    mem <= next_mem;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : bsma_ram

// [design/bsma_top.sv]
`timescale 1ns/100ps
// Functional notes
// R1: High RAM block answers at 0x3FA000-0x3FBFFF and at 0x00A000-0x00BFFF.
// R2: First low block at 0x008000/0x3F8000, second at 0x009000/0x3F9000, 4K each.
// R3: Both aliases of one block reach the same storage words.
// R4: Stack accesses reach only the lowest 64K words; higher ones are dropped.
// R5: Upper aliases within the top 64K range serve legacy-mode code.
// R6: Words 0x3F7FF8-0x3F7FFF are flagged as the code security password.
// R7: Board holds three boot pins stable; device samples them at reset release.
// R8: Pattern 1,1,1 jumps to flash entry 0x3F7FF6.
// R9: Patterns 110, 101, 100 call async serial, sync serial, two-wire loaders.
// R10: Pattern 011 calls the CAN loader; reserved when no CAN port exists.
// R11: Pattern 010 jumps to lowest RAM block start 0x000000.
// R12: Pattern 001 jumps to OTP entry; 000 calls the parallel pin loader.
module bsma_top
  import bsma_pkg::*;
#(
  parameter int                HIGH_DEPTH  = HIGH_RAM_DEPTH,
  parameter int                LOW_DEPTH   = LOW_RAM_DEPTH,
  parameter bit                CAN_PRESENT = 1'b1,
  parameter logic [ADDR_W-1:0] OTP_ENTRY   = OTP_ENTRY_DEFAULT
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Memory side
  input  wire bsma_req_t  req,
  output bsma_rsp_t       rsp,
  // Boot straps and boot decision
  input  wire bsma_pins_t pins,
  output bsma_boot_t      boot
);

  localparam int HIGH_AW = $clog2(HIGH_DEPTH);
  localparam int LOW_AW  = $clog2(LOW_DEPTH);

  if (HIGH_DEPTH != HIGH_RAM_DEPTH || LOW_DEPTH != LOW_RAM_DEPTH) begin : g_depth_check
    $error("bsma_top depths must match the decoded window sizes");
  end

  function automatic logic in_win(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base,
                                  input logic [ADDR_W-1:0] size);
    in_win = (a >= base) && (a < base + size);
  endfunction : in_win

  // Address decode.
  logic      hit_high;
  logic      hit_low0;
  logic      hit_low1;
  logic      sp_fault;
  logic      go;
  bsma_sel_t dec_sel;
  bsma_sel_t sel;
  bsma_rsp_t next_rsp;

  always_comb begin
    hit_high = in_win(req.addr, HIGH_RAM_LOW_BASE, HIGH_RAM_SIZE)
            || in_win(req.addr, HIGH_RAM_HIGH_BASE, HIGH_RAM_SIZE); // R1
    hit_low0 = in_win(req.addr, LOW0_RAM_LOW_BASE, LOW_RAM_SIZE)
            || in_win(req.addr, LOW0_RAM_HIGH_BASE, LOW_RAM_SIZE); // R2
    hit_low1 = in_win(req.addr, LOW1_RAM_LOW_BASE, LOW_RAM_SIZE)
            || in_win(req.addr, LOW1_RAM_HIGH_BASE, LOW_RAM_SIZE); // R2
    sp_fault = req.valid && req.sp_access && (req.addr >= SP_LIMIT); // R4
    go       = req.valid && !sp_fault;
    if (!go) begin
      dec_sel = BSMA_SEL_NONE;
    end else if (hit_high) begin
      dec_sel = BSMA_SEL_HIGH;
    end else if (hit_low0) begin
      dec_sel = BSMA_SEL_LOW0;
    end else if (hit_low1) begin
      dec_sel = BSMA_SEL_LOW1;
    end else begin
      dec_sel = BSMA_SEL_NONE;
    end
  end

  // Word offsets drop the alias bits, so both aliases land on one storage word.
  logic [DATA_W-1:0] rd_high;
  logic [DATA_W-1:0] rd_low0;
  logic [DATA_W-1:0] rd_low1;

  bsma_ram #(.DEPTH(HIGH_DEPTH), .AW(HIGH_AW)) u_high_ram_block (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .we      (req.write && dec_sel == BSMA_SEL_HIGH),
    .addr    (req.addr[HIGH_AW-1:0]), // R3
    .wdata   (req.wdata),
    .rdata   (rd_high)
  );

  bsma_ram #(.DEPTH(LOW_DEPTH), .AW(LOW_AW)) u_first_low_ram_block (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .we      (req.write && dec_sel == BSMA_SEL_LOW0),
    .addr    (req.addr[LOW_AW-1:0]), // R3
    .wdata   (req.wdata),
    .rdata   (rd_low0)
  );

  bsma_ram #(.DEPTH(LOW_DEPTH), .AW(LOW_AW)) u_second_low_ram_block (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .we      (req.write && dec_sel == BSMA_SEL_LOW1),
    .addr    (req.addr[LOW_AW-1:0]), // R3
    .wdata   (req.wdata),
    .rdata   (rd_low1)
  );

  always_comb begin
    next_rsp             = '0;
    next_rsp.valid       = req.valid;
    next_rsp.hit         = (dec_sel != BSMA_SEL_NONE);
    next_rsp.sp_fault    = sp_fault; // R4
    next_rsp.upper_alias = go && (req.addr >= UPPER_RANGE_BASE)
                        && (hit_high || hit_low0 || hit_low1); // R5
    next_rsp.pw_hit      = go && (req.addr >= PW_FIRST) && (req.addr <= PW_LAST); // R6
  end

  bsma_rsp_t rsp_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_q <= '0;
      sel   <= BSMA_SEL_NONE;
    end else begin
      rsp_q <= next_rsp;
      sel   <= dec_sel;
    end
  end

  // Read data is already registered in each block; only the select steers it.
  always_comb begin
    rsp = rsp_q;
    case (sel)
      BSMA_SEL_HIGH: rsp.rdata = rd_high;
      BSMA_SEL_LOW0: rsp.rdata = rd_low0;
      BSMA_SEL_LOW1: rsp.rdata = rd_low1;
      default:       rsp.rdata = '0;
    endcase
  end

  // Boot selection.
  bsma_boot_st_t   st;
  bsma_boot_st_t   next_st;
  bsma_boot_t      next_boot;
  bsma_boot_mode_t pin_mode;

  assign pin_mode = bsma_boot_mode_t'({pins.boot_select_first_pin,
                                       pins.boot_select_second_pin,
                                       pins.boot_select_third_pin});

  // Straps are taken once, on the first edge after release, and then held.
  always_comb begin
    next_st   = st;
    next_boot = boot;
    case (st)
      BSMA_ST_WAIT: begin
        next_st            = BSMA_ST_DONE;
        next_boot.valid    = 1'b1;
        next_boot.mode     = pin_mode; // R7
        next_boot.jump     = 1'b0;
        next_boot.reserved = 1'b0;
        next_boot.entry    = '0;
        case (pin_mode)
          BSMA_BOOT_FLASH: begin
            next_boot.jump  = 1'b1; // R8
            next_boot.entry = FLASH_ENTRY;
          end
          BSMA_BOOT_RAM: begin
            next_boot.jump  = 1'b1; // R11
            next_boot.entry = LOWEST_RAM_ENTRY;
          end
          BSMA_BOOT_OTP: begin
            next_boot.jump  = 1'b1; // R12
            next_boot.entry = OTP_ENTRY;
          end
          BSMA_BOOT_CAN: begin
            next_boot.reserved = !CAN_PRESENT; // R10
          end
          default: begin
            next_boot.jump = 1'b0; // R9
          end
        endcase
      end
      BSMA_ST_DONE: begin
        next_st = BSMA_ST_DONE;
      end
      default: begin
        next_st = BSMA_ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st   <= BSMA_ST_WAIT;
      boot <= '0;
    end else begin
      st   <= next_st;
      boot <= next_boot;
    end
  end

  // Assertions.
  a_high_alias_hit: assert property (@(posedge sys_clk) disable iff (!resetn) // R1
    (req.valid && !req.sp_access && in_win(req.addr, HIGH_RAM_HIGH_BASE, HIGH_RAM_SIZE))
      |=> (rsp.hit && sel == BSMA_SEL_HIGH))
    else $error("high RAM upper alias not decoded");

  a_low_alias_hit: assert property (@(posedge sys_clk) disable iff (!resetn) // R2
    (req.valid && in_win(req.addr, LOW1_RAM_LOW_BASE, LOW_RAM_SIZE))
      |=> (rsp.hit && sel == BSMA_SEL_LOW1))
    else $error("second low RAM block not decoded");

  a_alias_same_word: assert property (@(posedge sys_clk) disable iff (!resetn) // R3
    (req.valid && req.write && !req.sp_access
       && in_win(req.addr, HIGH_RAM_LOW_BASE, HIGH_RAM_SIZE))
      ##1 (req.valid && !req.write && !req.sp_access
             && req.addr == $past(req.addr) + (HIGH_RAM_HIGH_BASE - HIGH_RAM_LOW_BASE))
      |=> (rsp.rdata == $past(req.wdata, 2)))
    else $error("aliases do not share storage");

  a_stack_reach: assert property (@(posedge sys_clk) disable iff (!resetn) // R4
    (req.valid && req.sp_access && req.addr >= SP_LIMIT)
      |=> (rsp.sp_fault && !rsp.hit))
    else $error("stack access above 64K not refused");

  a_upper_alias: assert property (@(posedge sys_clk) disable iff (!resetn) // R5
    (req.valid && !req.sp_access && in_win(req.addr, LOW0_RAM_HIGH_BASE, LOW_RAM_SIZE))
      |=> (rsp.upper_alias && rsp.hit))
    else $error("upper alias not flagged");

  a_password_flag: assert property (@(posedge sys_clk) disable iff (!resetn) // R6
    (req.valid && !req.sp_access && req.addr >= PW_FIRST && req.addr <= PW_LAST)
      |=> (rsp.pw_hit && !rsp.hit))
    else $error("password word not flagged");

  a_boot_sample: assert property (@(posedge sys_clk) disable iff (!resetn) // R7
    (!boot.valid) |=> (boot.valid && boot.mode == $past(pin_mode))
      ##1 (boot.valid && $stable(boot.mode)))
    else $error("boot straps not sampled and held");

  a_boot_flash: assert property (@(posedge sys_clk) disable iff (!resetn) // R8
    (boot.valid && boot.mode == BSMA_BOOT_FLASH) |-> (boot.jump && boot.entry == FLASH_ENTRY))
    else $error("flash boot entry wrong");

  a_boot_loaders: assert property (@(posedge sys_clk) disable iff (!resetn) // R9
    (boot.valid && boot.mode[2] && boot.mode != BSMA_BOOT_FLASH) |-> (!boot.jump && !boot.reserved))
    else $error("serial loader pattern marked as jump");

  a_boot_can: assert property (@(posedge sys_clk) disable iff (!resetn) // R10
    (boot.valid && boot.mode == BSMA_BOOT_CAN) |-> (boot.reserved == !CAN_PRESENT && !boot.jump))
    else $error("CAN loader pattern handled wrongly");

  a_boot_ram: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    (boot.valid && boot.mode == BSMA_BOOT_RAM) |-> (boot.jump && boot.entry == LOWEST_RAM_ENTRY))
    else $error("RAM boot entry wrong");

  a_boot_otp: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    (boot.valid && boot.mode == BSMA_BOOT_OTP) |-> (boot.jump && boot.entry == OTP_ENTRY))
    else $error("OTP boot entry wrong");

endmodule : bsma_top

// [dv/boot_select_memory_alias_bench.sv]
`timescale 1ns/100ps
module boot_select_memory_alias_bench
  import bsma_pkg::*;
;
  typedef struct packed {
    logic              wr;
    logic              sp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        flags;
  } bsma_row_t;

  localparam int N = 17;

  logic        sys_clk;
  logic        resetn;
  bsma_req_t   req;
  bsma_rsp_t   rsp;
  bsma_pins_t  pins;
  bsma_boot_t  boot;
  logic [2:0]  pattern;
  logic        late_change;
  int          n_fail;
  int          comparisons;
  bsma_row_t   rows [N];
  logic        exp_jump;
  logic [ADDR_W-1:0] exp_entry;

  bsma_top bsma_top_i (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .req     (req),
    .rsp     (rsp),
    .pins    (pins),
    .boot    (boot)
  );

  bsma_strap_model bsma_strap_model_i (
    .resetn      (resetn),
    .pattern     (pattern),
    .late_change (late_change),
    .pins        (pins)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Outputs must read zero at the end of the reset hold.
  task automatic do_reset();
    resetn = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("rsp_in_reset", 32'(rsp), 32'h0);
    check("boot_in_reset", 32'(boot), 32'h0);
    resetn = 1'b1;
  endtask : do_reset

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    sys_clk     = 1'b0;
    resetn      = 1'b0;
    req         = '0;
    pattern     = 3'h7;
    late_change = 1'b0;
    n_fail      = 0;
    comparisons = 0;
    // Flags are hit, stack fault, upper alias, password word.
    rows = '{
      '{1'b1, 1'b0, 22'h00a005, 16'h1234, 4'h8},
      '{1'b0, 1'b0, 22'h3fa005, 16'h1234, 4'ha},
      '{1'b1, 1'b0, 22'h3f8fff, 16'ha5a5, 4'ha},
      '{1'b0, 1'b0, 22'h008fff, 16'ha5a5, 4'h8},
      '{1'b1, 1'b0, 22'h009000, 16'h5a5a, 4'h8},
      '{1'b0, 1'b0, 22'h3f9000, 16'h5a5a, 4'ha},
      '{1'b1, 1'b0, 22'h3fbfff, 16'h0f0f, 4'ha},
      '{1'b0, 1'b0, 22'h00bfff, 16'h0f0f, 4'h8},
      '{1'b0, 1'b0, 22'h00c000, 16'h0000, 4'h0},
      '{1'b0, 1'b0, 22'h3f7ff8, 16'h0000, 4'h1},
      '{1'b0, 1'b0, 22'h3f7fff, 16'h0000, 4'h1},
      '{1'b0, 1'b0, 22'h3f7ff7, 16'h0000, 4'h0},
      '{1'b0, 1'b0, 22'h007fff, 16'h0000, 4'h0},
      '{1'b1, 1'b1, 22'h00a006, 16'h1111, 4'h8},
      '{1'b1, 1'b1, 22'h3fa005, 16'hffff, 4'h4},
      '{1'b0, 1'b1, 22'h3fa006, 16'h0000, 4'h4},
      '{1'b0, 1'b1, 22'h00a005, 16'h1234, 4'h8}
    };
    @(negedge sys_clk);
    do_reset();
    // Back-to-back requests: each answer is checked while the next is driven.
    for (int i = 0; i <= N; i++) begin
      @(negedge sys_clk);
      if (i > 0) begin
        check("rsp_flags", 32'({rsp.valid, rsp.hit, rsp.sp_fault, rsp.upper_alias, rsp.pw_hit}),
              32'({1'b1, rows[i-1].flags}));
        if (!rows[i-1].wr || rows[i-1].flags[2]) begin
          // A refused stack access returns zero, whatever data it carried.
          check("rsp_rdata", 32'(rsp.rdata),
                rows[i-1].flags[2] ? 32'h0 : 32'(rows[i-1].data));
        end
      end
      if (i < N) begin
        req = '{1'b1, rows[i].wr, rows[i].sp, rows[i].addr, rows[i].data};
      end else begin
        req = '0;
      end
    end
    @(negedge sys_clk);
    check("rsp_valid_idle", 32'(rsp.valid), 32'h0);
    // Every strap pattern, each under its own reset, then a late pin change.
    for (int p = 0; p < 8; p++) begin
      pattern = p[2:0];
      do_reset();
      @(negedge sys_clk);
      exp_jump  = (p == 7 || p == 2 || p == 1);
      exp_entry = (p == 7) ? FLASH_ENTRY : (p == 2) ? LOWEST_RAM_ENTRY :
                  (p == 1) ? OTP_ENTRY_DEFAULT : 22'h000000;
      check("boot_mode", 32'({boot.valid, boot.mode, boot.jump, boot.reserved}),
            32'({1'b1, p[2:0], exp_jump, 1'b0}));
      check("boot_entry", 32'(boot.entry), 32'(exp_entry));
      late_change = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("boot_after_pins", 32'({boot.valid, boot.mode}), 32'({1'b1, p[2:0]}));
      late_change = 1'b0;
    end
    report_and_stop();
  end
endmodule : boot_select_memory_alias_bench

// [dv/bsma_strap_model.sv]
`timescale 1ns/100ps
module bsma_strap_model
  import bsma_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'b1
) (
  // Board control
  input  wire logic       resetn,
  input  wire logic [2:0] pattern,
  input  wire logic       late_change,
  // Strap pins
  output bsma_pins_t      pins
);
  logic [2:0] held;

  // Straps only settle while reset is held, so they are stable before release.
  // A board without the CAN port never offers the reserved pattern.
  // A latch process also runs at time zero, so the pins are never unknown at the first release.
  always_latch begin
    if (!resetn) begin
      held <= (!CAN_PRESENT && pattern == 3'h3) ? 3'h7 : pattern;
    end
  end

  // After release the board may reuse the pins, which the device must ignore.
  assign pins = bsma_pins_t'(late_change ? ~held : held);
endmodule : bsma_strap_model
